/* File: hdl/sss_top.sv */
// dwell sequencer, error queue reader and status query replies of the supply
// Overview of operation
// - dwell accepted from 10 ms up to 9997 s, reserved codes apart
// - dwell 0 reached while sequencing stops output like a halt
// - dwell 9998 makes the next location zero
// - dwell 9999 holds the location until a start advances it or a halt
// - start cuts dwell short and advances; halt stops output at once
// - dwell query returns value stored at the current location
// - errors kept first in first out; each read removes the oldest
// - error reply is signed number plus message text
// - empty queue reads as code 0 with no-error message
// - excess errors replaced by final overflow entry -350
// - operational word read-only, live, no sticky bits
// - operational bits 0-5: sequence, ramp, frozen, local, outside, trigger
// - bits 6-11: idle, energized, cv, sensing, cc, idle-or-fault; 12-15 zero
// - questionable word read-only, live protection conditions
// - questionable bits 0-4: voltage, current, phase, program line, heat
// - bit 5 fuse, 6 unused, 7 alarm, 8 interlock, 9 host; 10-15 zero
// - output-state query gives 1 energized, 0 off
// - version query gives firmware then hardware revision
// - measurement queries give measured voltage and current
// - after location 99 the sequencer wraps to 0
module sss_top #(
   parameter int unsigned TICK_CYCLES = sss_pkg::TICK_CYC,
   parameter int          ERR_DEPTH   = sss_pkg::ERR_DEPTH,
   parameter logic [15:0] FW_REV      = 16'h0100, // arbitrary value
   parameter logic [15:0] HW_REV      = 16'h0100  // arbitrary value
) (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        cmd_valid,
   input  wire logic [3:0]  cmd_code,
   input  wire logic [19:0] cmd_arg,
   input  wire logic        err_push,
   input  wire logic [15:0] err_code,
   input  wire logic        soft_ramp,
   input  wire logic        panel_frozen,
   input  wire logic        local_control,
   input  wire logic        outside_control,
   input  wire logic        awaiting_trigger,
   input  wire logic        constant_voltage,
   input  wire logic        distant_sensing,
   input  wire logic        constant_current,
   input  wire logic        voltage_trip,
   input  wire logic        current_trip,
   input  wire logic        phase_imbalance_trip,
   input  wire logic        program_line_trip,
   input  wire logic        heat_trip,
   input  wire logic        mains_fuse_trip,
   input  wire logic        alarm_tripped,
   input  wire logic        interlock_open,
   input  wire logic        host_control_flag,
   input  wire logic [31:0] meas_voltage,
   input  wire logic [31:0] meas_current,
   output logic             output_energized,
   output logic [6:0]       seq_location,
   output logic             rsp_valid,
   output logic [31:0]      rsp_data,
   output logic [2:0]       rsp_msg
);
   sss_pkg::sss_state_t st_q, st_d;
   logic [6:0]  loc_q, loc_d, nxt_loc;
   logic [19:0] cnt_q, cnt_d;
   logic        on_q, on_d, arm_q, arm_d, pend_q, pend_d;
   logic        start, halt, tick, tick_clr, wr_en, bad_wr, good_wr;
   logic [19:0] dwell;
   logic [19:0] dwell_mem [sss_pkg::LOC_COUNT];
   logic [15:0] oper_w, ques_w, head;
   logic        empty, pop, push;
   logic [15:0] push_code;
   logic        rsp_v_q, rsp_v_d;
   logic [31:0] rsp_dat_q, rsp_dat_d;
   logic [2:0]  msg_q, msg_d;

   assign dwell = dwell_mem[loc_q];

   // per-location dwell store, one register per location
   genvar gi;
   generate
      for (gi = 0; gi < sss_pkg::LOC_COUNT; gi++) begin : g_loc
         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               dwell_mem[gi] <= sss_pkg::DWELL_RST;
            end else if (wr_en && loc_q == 7'(gi)) begin
               dwell_mem[gi] <= cmd_arg;
            end
         end
      end
   endgenerate

   sss_tick #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tick (
      .mclk  (mclk),
      .rst_n (rst_n),
      .clr   (tick_clr),
      .tick  (tick)
   );

   // sequencer
   always_comb begin
      start    = cmd_valid && cmd_code == sss_pkg::CMD_START;
      halt     = cmd_valid && cmd_code == sss_pkg::CMD_HALT;
      good_wr  = (cmd_arg >= sss_pkg::DWELL_MIN && cmd_arg <= sss_pkg::DWELL_MAX)
                 || cmd_arg == sss_pkg::DWELL_STOP || cmd_arg == sss_pkg::DWELL_WRAP
                 || cmd_arg == sss_pkg::DWELL_HOLD;
      wr_en    = cmd_valid && cmd_code == sss_pkg::CMD_SET_DWELL && good_wr;
      bad_wr   = cmd_valid && cmd_code == sss_pkg::CMD_SET_DWELL && !good_wr;
      nxt_loc  = (dwell == sss_pkg::DWELL_WRAP || loc_q == sss_pkg::LOC_MAX) ?
                 7'h00 : loc_q + 7'h01;
      st_d     = st_q;
      loc_d    = loc_q;
      cnt_d    = cnt_q;
      on_d     = on_q;
      arm_d    = arm_q;
      tick_clr = 1'b0;
      if (cmd_valid && cmd_code == sss_pkg::CMD_ARM) begin
         arm_d = cmd_arg[0];
      end
      case (st_q)
         sss_pkg::S_OFF: begin
            if (cmd_valid && cmd_code == sss_pkg::CMD_SEL_LOC) begin
               loc_d = (cmd_arg[6:0] > sss_pkg::LOC_MAX) ? loc_q : cmd_arg[6:0];
            end
            if (start && !alarm_tripped) begin
               on_d     = 1'b1;
               st_d     = arm_q ? sss_pkg::S_DWELL : sss_pkg::S_ON;
               cnt_d    = 20'h0;
               tick_clr = 1'b1;
            end
         end
         sss_pkg::S_ON: begin
         end
         sss_pkg::S_DWELL: begin
            if (start) begin
               loc_d    = nxt_loc;
               cnt_d    = 20'h0;
               tick_clr = 1'b1;
            end else if (dwell == sss_pkg::DWELL_STOP) begin
               on_d = 1'b0;
               st_d = sss_pkg::S_OFF;
            end else if (dwell == sss_pkg::DWELL_HOLD) begin
               st_d = sss_pkg::S_HOLD;
            end else if (dwell == sss_pkg::DWELL_WRAP) begin
               loc_d    = 7'h00;
               cnt_d    = 20'h0;
               tick_clr = 1'b1;
            end else if (tick) begin
               if (cnt_q >= dwell - 20'h1) begin
                  loc_d    = nxt_loc;
                  cnt_d    = 20'h0;
                  tick_clr = 1'b1;
               end else begin
                  cnt_d = cnt_q + 20'h1;
               end
            end
         end
         sss_pkg::S_HOLD: begin
            if (start) begin
               loc_d    = nxt_loc;
               st_d     = sss_pkg::S_DWELL;
               cnt_d    = 20'h0;
               tick_clr = 1'b1;
            end
         end
         default: begin
            st_d = sss_pkg::S_OFF;
            on_d = 1'b0;
         end
      endcase
      // a latched protection trip drops the contactor just like a halt
      if (halt || alarm_tripped) begin
         st_d = sss_pkg::S_OFF;
         on_d = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_q  <= sss_pkg::S_OFF;
         loc_q <= sss_pkg::LOC_RST;
         cnt_q <= 20'h0;
         on_q  <= 1'b0;
         arm_q <= 1'b0;
      end else begin
         st_q  <= st_d;
         loc_q <= loc_d;
         cnt_q <= cnt_d;
         on_q  <= on_d;
         arm_q <= arm_d;
      end
   end

   // a rejected dwell write waits here one cycle, and longer while an outside error owns the push slot
   always_comb begin
      push      = err_push | pend_q;
      push_code = err_push ? err_code : sss_pkg::ERR_RANGE;
      pend_d    = (pend_q & err_push) | bad_wr;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pend_q <= 1'b0;
      end else begin
         pend_q <= pend_d;
      end
   end

   sss_err_fifo #(
      .DEPTH (ERR_DEPTH),
      .W     (sss_pkg::EW)
   ) u_errq (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .push      (push),
      .push_code (push_code),
      .pop       (pop),
      .head      (head),
      .empty     (empty)
   );

   // live status words, sampled only at the moment of the query
   always_comb begin
      oper_w                         = 16'h0000;
      oper_w[sss_pkg::OP_SEQ]        = arm_q;
      oper_w[sss_pkg::OP_RAMP]       = soft_ramp;
      oper_w[sss_pkg::OP_FROZEN]     = panel_frozen;
      oper_w[sss_pkg::OP_LOCAL]      = local_control;
      oper_w[sss_pkg::OP_OUTSIDE]    = outside_control;
      oper_w[sss_pkg::OP_TRIG]       = awaiting_trigger;
      oper_w[sss_pkg::OP_IDLE]       = !on_q;
      oper_w[sss_pkg::OP_PWR]        = on_q;
      oper_w[sss_pkg::OP_CV]         = constant_voltage;
      oper_w[sss_pkg::OP_RSENSE]     = distant_sensing;
      oper_w[sss_pkg::OP_CC]         = constant_current;
      oper_w[sss_pkg::OP_IDLE_FAULT] = !on_q | alarm_tripped;
      ques_w                         = 16'h0000;
      ques_w[sss_pkg::QU_VOLT]       = voltage_trip;
      ques_w[sss_pkg::QU_CURR]       = current_trip;
      ques_w[sss_pkg::QU_PHASE]      = phase_imbalance_trip;
      ques_w[sss_pkg::QU_PROG]       = program_line_trip;
      ques_w[sss_pkg::QU_HEAT]       = heat_trip;
      ques_w[sss_pkg::QU_FUSE]       = mains_fuse_trip;
      ques_w[sss_pkg::QU_ALARM]      = alarm_tripped;
      ques_w[sss_pkg::QU_ILOCK]      = interlock_open;
      ques_w[sss_pkg::QU_HOST]       = host_control_flag;
   end

   // query replies, one cycle after the query
   always_comb begin
      rsp_v_d   = 1'b0;
      rsp_dat_d = rsp_dat_q;
      msg_d     = msg_q;
      pop       = 1'b0;
      if (cmd_valid) begin
         rsp_v_d = 1'b1;
         msg_d   = sss_pkg::MSG_NONE;
         case (cmd_code)
            sss_pkg::Q_DWELL: rsp_dat_d = {12'h000, dwell};
            sss_pkg::Q_ERR: begin
               pop = !empty;
               if (empty) begin
                  rsp_dat_d = 32'h0;
                  msg_d     = sss_pkg::MSG_NO_ERROR;
               end else begin
                  rsp_dat_d = {{16{head[15]}}, head};
                  if (head == sss_pkg::ERR_OVF) begin
                     msg_d = sss_pkg::MSG_OVERFLOW;
                  end else if (head == sss_pkg::ERR_RANGE) begin
                     msg_d = sss_pkg::MSG_RANGE;
                  end else begin
                     msg_d = sss_pkg::MSG_OTHER;
                  end
               end
            end
            sss_pkg::Q_OPER: rsp_dat_d = {16'h0000, oper_w};
            sss_pkg::Q_QUES: rsp_dat_d = {16'h0000, ques_w};
            sss_pkg::Q_OUTPUT_STATE_QUERY: rsp_dat_d = {31'h0, on_q};
            sss_pkg::Q_VERS: begin
               rsp_dat_d = {FW_REV, HW_REV};
               msg_d     = sss_pkg::MSG_VERSION;
            end
            sss_pkg::Q_MVOLT: rsp_dat_d = meas_voltage;
            sss_pkg::Q_MCURR: rsp_dat_d = meas_current;
            default: rsp_v_d = 1'b0;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_v_q   <= 1'b0;
         rsp_dat_q <= 32'h0;
         msg_q     <= sss_pkg::MSG_NONE;
      end else begin
         rsp_v_q   <= rsp_v_d;
         rsp_dat_q <= rsp_dat_d;
         msg_q     <= msg_d;
      end
   end

   assign output_energized = on_q;
   assign seq_location     = loc_q;
   assign rsp_valid        = rsp_v_q;
   assign rsp_data         = rsp_dat_q;
   assign rsp_msg          = msg_q;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_quiet;
      !start && !halt && !alarm_tripped;
   endsequence
   sequence s_at_dwell(logic [19:0] v);
      st_q == sss_pkg::S_DWELL && dwell == v ##0 s_quiet;
   endsequence

   property p_stop_zero;
      s_at_dwell(sss_pkg::DWELL_STOP) |=> !on_q && st_q == sss_pkg::S_OFF;
   endproperty
   a_stop_zero: assert property (p_stop_zero) else $error("dwell 0 did not stop");

   property p_wrap_code;
      s_at_dwell(sss_pkg::DWELL_WRAP) |=> loc_q == 7'h00 && cnt_q == 20'h0;
   endproperty
   a_wrap_code: assert property (p_wrap_code) else $error("wrap code not to 0");

   property p_hold;
      (st_q == sss_pkg::S_HOLD) ##0 s_quiet |=> st_q == sss_pkg::S_HOLD && $stable(loc_q);
   endproperty
   a_hold: assert property (p_hold) else $error("hold location moved");

   property p_start_adv;
      (st_q != sss_pkg::S_OFF && st_q != sss_pkg::S_ON && start && !halt && !alarm_tripped
       && dwell != sss_pkg::DWELL_WRAP && loc_q != sss_pkg::LOC_MAX)
      |=> loc_q == $past(loc_q) + 7'h01 && on_q;
   endproperty
   a_start_adv: assert property (p_start_adv) else $error("start did not advance");

   property p_halt;
      halt |=> !on_q && st_q == sss_pkg::S_OFF;
   endproperty
   a_halt: assert property (p_halt) else $error("halt left output on");

   property p_last_wrap;
      (st_q == sss_pkg::S_DWELL && start && !halt && !alarm_tripped
       && loc_q == sss_pkg::LOC_MAX) |=> loc_q == 7'h00;
   endproperty
   a_last_wrap: assert property (p_last_wrap) else $error("no wrap after 99");

   property p_tick_adv;
      (st_q == sss_pkg::S_DWELL && tick && dwell != sss_pkg::DWELL_STOP
       && dwell != sss_pkg::DWELL_HOLD && dwell != sss_pkg::DWELL_WRAP
       && cnt_q < dwell - 20'h1) ##0 s_quiet |=> cnt_q == $past(cnt_q) + 20'h1;
   endproperty
   a_tick_adv: assert property (p_tick_adv) else $error("tick not counted");

   property p_dwell_q;
      (cmd_valid && cmd_code == sss_pkg::Q_DWELL) |=> rsp_valid && rsp_data == {12'h0, $past(dwell)};
   endproperty
   a_dwell_q: assert property (p_dwell_q) else $error("dwell reply wrong");

   property p_err_empty;
      (cmd_valid && cmd_code == sss_pkg::Q_ERR && empty)
      |=> rsp_data == 32'h0 && rsp_msg == sss_pkg::MSG_NO_ERROR;
   endproperty
   a_err_empty: assert property (p_err_empty) else $error("empty queue reply wrong");

   property p_oper;
      (cmd_valid && cmd_code == sss_pkg::Q_OPER)
      |=> rsp_data[31:12] == 20'h0 && rsp_data[7] == $past(on_q) && rsp_data[6] != rsp_data[7];
   endproperty
   a_oper: assert property (p_oper) else $error("operational word wrong");

   property p_ques;
      (cmd_valid && cmd_code == sss_pkg::Q_QUES)
      |=> rsp_data[6] == 1'b0 && rsp_data[31:10] == 22'h0 && rsp_data[0] == $past(voltage_trip);
   endproperty
   a_ques: assert property (p_ques) else $error("questionable word wrong");

   property p_output_state_query;
      (cmd_valid && cmd_code == sss_pkg::Q_OUTPUT_STATE_QUERY) |=> rsp_data == {31'h0, $past(on_q)};
   endproperty
   a_output_state_query: assert property (p_output_state_query) else $error("output state reply wrong");

   property p_bad_dwell;
      (cmd_valid && cmd_code == sss_pkg::CMD_SET_DWELL && !good_wr) |=> $stable(dwell) || $changed(loc_q);
   endproperty
   a_bad_dwell: assert property (p_bad_dwell) else $error("bad dwell was stored");
endmodule : sss_top

/* File: pkg/sss_pkg.sv */
// constants, commands and states shared by the supply sequence and status logic
package sss_pkg;

   localparam int unsigned CLK_HZ       = 125_000_000;
   localparam int unsigned TICK_MS      = 10;
   localparam int unsigned TICK_CYC     = (CLK_HZ / 1000) * TICK_MS;

   localparam int          DW           = 20;
   localparam int          LW           = 7;
   localparam int          LOC_COUNT    = 100;
   localparam logic [6:0]  LOC_MAX      = 7'h63;
   localparam logic [6:0]  LOC_RST      = 7'h00;

   // dwell values are hundredths of a second, one count per 10 ms tick
   localparam logic [19:0] DWELL_MIN    = 20'h00001;
   localparam logic [19:0] DWELL_MAX    = 20'hf4114;
   localparam logic [19:0] DWELL_STOP   = 20'h00000;
   localparam logic [19:0] DWELL_WRAP   = 20'hf4178;
   localparam logic [19:0] DWELL_HOLD   = 20'hf41dc;
   localparam logic [19:0] DWELL_RST    = 20'h00064;

   localparam int          ERR_DEPTH    = 8;
   localparam int          EW           = 16;
   localparam logic [15:0] ERR_NONE     = 16'h0000;
   localparam logic [15:0] ERR_OVF      = 16'hfea2;
   localparam logic [15:0] ERR_RANGE    = 16'hff22;

   localparam int OP_SEQ = 0, OP_RAMP = 1, OP_FROZEN = 2, OP_LOCAL = 3;
   localparam int OP_OUTSIDE = 4, OP_TRIG = 5, OP_IDLE = 6, OP_PWR = 7;
   localparam int OP_CV = 8, OP_RSENSE = 9, OP_CC = 10, OP_IDLE_FAULT = 11;
   localparam int QU_VOLT = 0, QU_CURR = 1, QU_PHASE = 2, QU_PROG = 3;
   localparam int QU_HEAT = 4, QU_FUSE = 5, QU_ALARM = 7, QU_ILOCK = 8;
   localparam int QU_HOST = 9;

   typedef enum logic [3:0] {
      CMD_NOP = 4'h0, CMD_START = 4'h1, CMD_HALT = 4'h2, CMD_ARM = 4'h3,
      CMD_SEL_LOC = 4'h4, CMD_SET_DWELL = 4'h5, Q_DWELL = 4'h6, Q_ERR = 4'h7,
      Q_OPER = 4'h8, Q_QUES = 4'h9, Q_OUTPUT_STATE_QUERY = 4'ha, Q_VERS = 4'hb,
      Q_MVOLT = 4'hc, Q_MCURR = 4'hd
   } sss_cmd_t;

   typedef enum logic [2:0] {
      MSG_NONE = 3'h0, MSG_NO_ERROR = 3'h1, MSG_OVERFLOW = 3'h2,
      MSG_RANGE = 3'h3, MSG_OTHER = 3'h4, MSG_VERSION = 3'h5
   } sss_msg_t;

   typedef enum logic [1:0] {
      S_OFF = 2'b00, S_DWELL = 2'b01, S_HOLD = 2'b11, S_ON = 2'b10
   } sss_state_t;

endpackage : sss_pkg

/* File: hdl/sss_tick.sv */
// free 10 ms tick generator, restarted on entry to a location
module sss_tick #(
   parameter int unsigned TICK_CYCLES = sss_pkg::TICK_CYC
) (
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic clr,
   output logic      tick
);
   logic [31:0] cnt_q, cnt_d;
   logic        tick_q, tick_d;

   always_comb begin
      tick_d = 1'b0;
      cnt_d  = cnt_q + 32'h1;
      if (clr) begin
         cnt_d = 32'h0;
      end else if (cnt_q >= TICK_CYCLES - 1) begin
         cnt_d  = 32'h0;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q  <= 32'h0;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign tick = tick_q;
endmodule : sss_tick

/* File: hdl/sss_err_fifo.sv */
// error queue, oldest first, newest slot kept for the overflow code
module sss_err_fifo #(
   parameter int DEPTH = sss_pkg::ERR_DEPTH,
   parameter int W     = sss_pkg::EW
) (
   input  wire logic         mclk,
   input  wire logic         rst_n,
   input  wire logic         push,
   input  wire logic [W-1:0] push_code,
   input  wire logic         pop,
   output logic [W-1:0]      head,
   output logic              empty
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] LAST = CW'(DEPTH - 1);

   logic [W-1:0]  mem_q [DEPTH];
   logic [PW-1:0] rd_q, rd_d, wr_q, wr_d;
   logic [CW-1:0] cnt_q, cnt_d, c1;
   logic          do_pop, do_wr;
   logic [W-1:0]  wr_val;

   always_comb begin
      do_pop = pop & (cnt_q != '0);
      c1     = cnt_q - CW'(do_pop);
      do_wr  = push & (c1 <= LAST);
      wr_val = (c1 == LAST) ? sss_pkg::ERR_OVF : push_code;
      rd_d   = rd_q;
      wr_d   = wr_q;
      if (do_pop) begin
         rd_d = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + PW'(1);
      end
      if (do_wr) begin
         wr_d = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + PW'(1);
      end
      cnt_d = c1 + CW'(do_wr);
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rd_q  <= '0;
         wr_q  <= '0;
         cnt_q <= '0;
      end else begin
         rd_q  <= rd_d;
         wr_q  <= wr_d;
         cnt_q <= cnt_d;
      end
   end

   always_ff @(posedge mclk) begin
      if (do_wr) begin
         mem_q[wr_q] <= wr_val;
      end
   end

   assign head  = mem_q[rd_q];
   assign empty = (cnt_q == '0);

   property p_ovf_slot;
      @(posedge mclk) disable iff (!rst_n)
      (push && !pop && cnt_q == LAST) |=> (mem_q[$past(wr_q)] == sss_pkg::ERR_OVF);
   endproperty
   a_ovf_slot: assert property (p_ovf_slot) else $error("overflow code missing");

   property p_full_drop;
      @(posedge mclk) disable iff (!rst_n)
      (!pop && cnt_q == CW'(DEPTH)) |=> (cnt_q == CW'(DEPTH) && $stable(wr_q));
   endproperty
   a_full_drop: assert property (p_full_drop) else $error("full queue took error");

   property p_pop_order;
      @(posedge mclk) disable iff (!rst_n)
      (pop && !push && cnt_q != '0) |=> (cnt_q == $past(cnt_q) - CW'(1));
   endproperty
   a_pop_order: assert property (p_pop_order) else $error("read did not remove");
endmodule : sss_err_fifo

/* File: dv/sss_host.sv */
// host model: issues one command per call and captures the reply
module sss_host (
   input  wire logic        mclk,
   output logic             cmd_valid,
   output logic [3:0]       cmd_code,
   output logic [19:0]      cmd_arg,
   input  wire logic        rsp_valid,
   input  wire logic [31:0] rsp_data,
   input  wire logic [2:0]  rsp_msg
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] last_data;
   logic [2:0]  last_msg;
   initial begin
      cmd_valid = 1'b0;
      cmd_code  = 4'h0;
      cmd_arg   = 20'h00000;
   end
   // start and halt go out through here like any other command
   task send(input sss_pkg::sss_cmd_t c, input logic [19:0] a);
      @(negedge mclk);
      cmd_valid = 1'b1;
      cmd_code  = c;
      cmd_arg   = a;
      @(negedge mclk);
      cmd_valid = 1'b0;
      // released lines flip so a stale value is never mistaken for a command
      cmd_code  = ~c;
      cmd_arg   = ~a;
      last_data = rsp_valid ? rsp_data : 32'hx;
      last_msg  = rsp_msg;
   endtask : send
endmodule : sss_host

/* File: dv/sss_top_tb.sv */
// self-checking bench for the supply sequence and status logic
module sss_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk = 1'b0, rst_n = 1'b0, err_push = 1'b0;
   logic [15:0] err_code = 16'h0000;
   logic [16:0] st = 17'h00000;
   logic [31:0] mv = 32'h12345678, mc = 32'h9abcdef0;
   logic        cmd_valid, rsp_valid, out_on;
   logic [3:0]  cmd_code;
   logic [19:0] cmd_arg;
   logic [31:0] rsp_data;
   logic [2:0]  rsp_msg;
   logic [6:0]  loc;
   int          n_errors = 0, checked = 0, cyc = 0;
   always #4 mclk = ~mclk;
   sss_host host (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_msg(rsp_msg));
   sss_top #(.TICK_CYCLES(4), .FW_REV(16'h0102), .HW_REV(16'h0304)) uut (
      .mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_arg(cmd_arg), .err_push(err_push), .err_code(err_code), .soft_ramp(st[0]),
      .panel_frozen(st[1]), .local_control(st[2]), .outside_control(st[3]),
      .awaiting_trigger(st[4]), .constant_voltage(st[5]), .distant_sensing(st[6]),
      .constant_current(st[7]), .voltage_trip(st[8]), .current_trip(st[9]),
      .phase_imbalance_trip(st[10]), .program_line_trip(st[11]), .heat_trip(st[12]),
      .mains_fuse_trip(st[13]), .alarm_tripped(st[14]), .interlock_open(st[15]),
      .host_control_flag(st[16]), .meas_voltage(mv), .meas_current(mc),
      .output_energized(out_on), .seq_location(loc), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .rsp_msg(rsp_msg));
   task report_and_stop;
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop
   task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", n, exp, got);
      end
   endtask : chk
   task q(input sss_pkg::sss_cmd_t c, input string n, input logic [31:0] e);
      host.send(c, 20'h00000);
      chk(n, host.last_data, e);
   endtask : q
   task set(input logic [6:0] l, input logic [19:0] d);
      host.send(sss_pkg::CMD_SEL_LOC, {13'h0000, l});
      host.send(sss_pkg::CMD_SET_DWELL, d);
   endtask : set
   // bounded wait for the stepper to reach a location
   task wt(input logic [6:0] l);
      for (int k = 0; k < 40 && loc !== l; k++) @(negedge mclk);
      chk("location", {25'h0, loc}, {25'h0, l});
   endtask : wt
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         report_and_stop;
      end
   end
   initial begin
      repeat (10) @(posedge mclk);
      @(negedge mclk) rst_n = 1'b1;
      q(sss_pkg::Q_OUTPUT_STATE_QUERY, "output off", 32'h0);
      q(sss_pkg::Q_ERR, "empty queue", 32'h0);
      chk("empty msg", {29'h0, host.last_msg}, {29'h0, sss_pkg::MSG_NO_ERROR});
      host.send(sss_pkg::CMD_SET_DWELL, 20'hf4115);
      q(sss_pkg::Q_DWELL, "dwell kept", 32'h00064);
      q(sss_pkg::Q_ERR, "range error", 32'hffffff22);
      chk("range msg", {29'h0, host.last_msg}, {29'h0, sss_pkg::MSG_RANGE});
      st = 17'h000ff;
      q(sss_pkg::Q_OPER, "oper all", 32'h0f7e);
      st = 17'h00055;
      q(sss_pkg::Q_OPER, "oper mix", 32'h0a6a);
      st = 17'h1ff00;
      q(sss_pkg::Q_QUES, "ques all", 32'h03bf);
      st = 17'h0aa00;
      q(sss_pkg::Q_QUES, "ques mix", 32'h012a);
      st = 17'h00000;
      q(sss_pkg::Q_MVOLT, "volts", mv);
      q(sss_pkg::Q_MCURR, "amps", mc);
      q(sss_pkg::Q_VERS, "version", 32'h01020304);
      chk("version msg", {29'h0, host.last_msg}, {29'h0, sss_pkg::MSG_VERSION});
      for (int i = 0; i < 10; i++) begin
         @(negedge mclk);
         err_push = 1'b1;
         err_code = 16'hff10 + 16'(i);
      end
      @(negedge mclk) err_push = 1'b0;
      for (int i = 0; i < 7; i++) q(sss_pkg::Q_ERR, "fifo", 32'hffffff10 + i);
      chk("other msg", {29'h0, host.last_msg}, {29'h0, sss_pkg::MSG_OTHER});
      q(sss_pkg::Q_ERR, "overflow", 32'hfffffea2);
      chk("ovf msg", {29'h0, host.last_msg}, {29'h0, sss_pkg::MSG_OVERFLOW});
      q(sss_pkg::Q_ERR, "drained", 32'h0);
      set(98, 20'h00002);
      set(99, 20'h00001);
      set(0, 20'h00000);
      host.send(sss_pkg::CMD_SEL_LOC, 20'h00062);
      host.send(sss_pkg::CMD_ARM, 20'h00001);
      host.send(sss_pkg::CMD_START, 20'h00000);
      chk("started", {31'h0, out_on}, 32'h1);
      wt(99);
      wt(0);
      repeat (2) @(negedge mclk);
      chk("stop on zero", {31'h0, out_on}, 32'h0);
      set(5, 20'hf41dc);
      set(6, 20'hf4178);
      set(0, 20'hf41dc);
      host.send(sss_pkg::CMD_SEL_LOC, 20'h00005);
      host.send(sss_pkg::CMD_START, 20'h00000);
      repeat (40) @(negedge mclk);
      chk("held", {25'h0, loc}, 32'h5);
      host.send(sss_pkg::CMD_START, 20'h00000);
      wt(0);
      q(sss_pkg::Q_OUTPUT_STATE_QUERY, "running", 32'h1);
      q(sss_pkg::Q_DWELL, "dwell here", 32'hf41dc);
      host.send(sss_pkg::CMD_HALT, 20'h00000);
      @(negedge mclk);
      chk("halted", {31'h0, out_on}, 32'h0);
      // unarmed start is normal mode: output on, location never steps
      host.send(sss_pkg::CMD_ARM, 20'h00000);
      host.send(sss_pkg::CMD_START, 20'h00000);
      repeat (20) @(negedge mclk);
      chk("normal still", {25'h0, loc}, 32'h0);
      q(sss_pkg::Q_OPER, "oper on", 32'h0080);
      report_and_stop;
   end
endmodule : sss_top_tb
